/* File: bcm_pkg.sv */
`default_nettype none
package bcm_pkg;
  localparam int CH_N   = 3;
  localparam int DW     = 32;
  localparam int ADDR_W = 8;

  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ADDR    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h0c;
  localparam logic [ADDR_W-1:0] CH_OFS_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] CH_AREA_END = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_BREAK   = 8'h38;
  localparam int CH_IDX_LSB = 4;

  // Channel control word fields
  localparam int CB_ADDR    = 0;
  localparam int CB_ADDR_PC = 1;
  localparam int CB_DATA    = 2;
  localparam int CB_SIZE    = 3;
  localparam int CB_XY      = 5;
  localparam int CB_XY_SEL  = 6;
  localparam int CB_XY_DATA = 7;
  localparam int CB_RW      = 8;
  localparam int CB_RW_SRC  = 9;
  localparam int CB_RW_LVL  = 10;
  localparam int CB_BST     = 11;
  localparam int CB_BTYPE   = 12;
  localparam int CB_BSEL    = 14;
  localparam int CB_IO      = 16;
  localparam int CB_CNT     = 17;
  localparam int CB_EN      = 31;
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BSEL_CPU_ALL  = 2'h0,
    BSEL_CPU_DATA = 2'h1,
    BSEL_IBUS     = 2'h2
  } bcm_bsel_t;

  typedef enum logic [1:0] {
    BST_IFETCH = 2'h0,
    BST_DREAD  = 2'h1,
    BST_DWRITE = 2'h2,
    BST_DMA    = 2'h3
  } bcm_bst_t;

  function automatic logic [DW-1:0] size_mask(input logic [1:0] sz);
    size_mask = (sz == SZ_BYTE) ? 32'h0000_00ff :
                (sz == SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction

  function automatic logic [DW-1:0] strb_merge(input logic [DW-1:0] old,
                                               input logic [DW-1:0] wd,
                                               input logic [3:0]    strb);
    integer b;
    strb_merge = old;
    for (b = 0; b < 4; b = b + 1) begin
      if (strb[b]) begin
        strb_merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  function automatic bcm_bst_t bst_code(input logic ifetch,
                                        input logic dma,
                                        input logic read_write_dir);
    bst_code = ifetch ? BST_IFETCH : dma ? BST_DMA :
               read_write_dir ? BST_DREAD : BST_DWRITE;
  endfunction
endpackage
`default_nettype wire

/* File: bcm_chan.sv */
`timescale 1ns/10ps
`default_nettype none
module bcm_chan
  import bcm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Configuration
  input  wire logic [DW-1:0]    ctrl,
  input  wire logic [DW-1:0]    cmp_addr,
  input  wire logic [DW-1:0]    cmp_data,
  input  wire logic [CNT_W-1:0] cnt_init,
  input  wire logic             reload,
  // Observed cycle
  input  wire logic             cyc_valid,
  input  wire logic [DW-1:0]    cyc_addr,
  input  wire logic [DW-1:0]    cyc_data,
  input  wire logic [1:0]       cyc_size,
  input  wire logic             cyc_rd_n,
  input  wire logic             cyc_read_write_dir,
  input  wire bcm_bst_t         cyc_type,
  input  wire logic             cyc_io,
  // Result
  output logic                  hit,
  output logic [CNT_W-1:0]      cnt_left
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  wire addr_ok = !ctrl[CB_ADDR] || (cyc_addr == cmp_addr);
  wire data_ok = !ctrl[CB_DATA] || ((cyc_size == ctrl[CB_SIZE +: 2]) &&
                 (((cyc_data ^ cmp_data) & size_mask(cyc_size)) == '0));
  wire xy_ok   = !ctrl[CB_XY] || (ctrl[CB_XY_DATA] ?
                 (cyc_data == cmp_data) : (cyc_addr == cmp_addr));
  wire rw_lvl  = ctrl[CB_RW_SRC] ? cyc_read_write_dir : cyc_rd_n;
  wire rw_ok   = !ctrl[CB_RW] || (rw_lvl == ctrl[CB_RW_LVL]);
  wire bst_ok  = !ctrl[CB_BST] ||
                 (cyc_type == bcm_bst_t'(ctrl[CB_BTYPE +: 2]));
  wire io_ok   = !ctrl[CB_IO] || cyc_io;
  wire any_en  = ctrl[CB_ADDR] | ctrl[CB_DATA] | ctrl[CB_XY] |
                 ctrl[CB_RW] | ctrl[CB_BST] | ctrl[CB_IO];
  wire cond    = ctrl[CB_EN] && any_en && cyc_valid && !reload &&
                 addr_ok && data_ok && xy_ok && rw_ok && bst_ok && io_ok;
  wire cnt_on  = ctrl[CB_CNT];
  wire last    = (cnt_q <= CNT_W'(1));

  assign hit      = cond && (!cnt_on || last);
  assign cnt_left = cnt_q;

  assign cnt_d = reload ? cnt_init :
                 (cond && cnt_on) ? (last ? cnt_init : cnt_q - CNT_W'(1)) :
                 cnt_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

/* File: bcm_axil.sv */
`timescale 1ns/10ps
`default_nettype none
module bcm_axil
  import bcm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [DW-1:0]     s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [DW-1:0]          s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Register side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DW-1:0]          wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [DW-1:0]     rd_data,
  input  wire logic              rd_err
);
  logic aw_v_q;
  logic w_v_q;

  assign s_awready = !aw_v_q && !s_bvalid;
  assign s_wready  = !w_v_q && !s_bvalid;
  assign wr_en     = aw_v_q && w_v_q && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign rd_en     = s_arvalid && s_arready;
  assign rd_addr   = s_araddr;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_v_q   <= 1'b0;
      w_v_q    <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
      wr_strb  <= '0;
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_v_q  <= 1'b1;
        wr_addr <= s_awaddr;
      end else if (wr_en) begin
        aw_v_q <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_v_q   <= 1'b1;
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
      end else if (wr_en) begin
        w_v_q <= 1'b0;
      end
      if (wr_en) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= RESP_OKAY;
    end else if (rd_en) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_data;
      s_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: bcm_top.sv */
// Contract
// - three independent break condition channels
// - address or program counter equals compare
// - data equals compare at chosen size
// - X or Y bus address/data equals compare
// - read strobe or direction level matches
// - bus cycle type matches selection
// - processor bus all: fetches and data
// - processor bus data: data only
// - system bus: cache misses and DMA
// - any on-chip peripheral access breaks
// - break after conditions met N times
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module bcm_top
  import bcm_pkg::*;
#(
  parameter int              CNT_W   = 16,
  parameter logic [DW-1:0]   IO_MASK = 32'hff00_0000,
  parameter logic [DW-1:0]   IO_BASE = 32'hff00_0000
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // AXI4-Lite register bus
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [DW-1:0]     s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [DW-1:0]          s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Processor-side bus
  input  wire logic              lbus_valid,
  input  wire logic              lbus_ifetch,
  input  wire logic [DW-1:0]     lbus_addr,
  input  wire logic [DW-1:0]     lbus_data,
  input  wire logic [1:0]        lbus_size,
  input  wire logic              lbus_rd_n,
  input  wire logic              lbus_read_write_dir,
  // Internal system bus
  input  wire logic              ibus_valid,
  input  wire logic              ibus_ifetch,
  input  wire logic              ibus_dma,
  input  wire logic [DW-1:0]     ibus_addr,
  input  wire logic [DW-1:0]     ibus_data,
  input  wire logic [1:0]        ibus_size,
  input  wire logic              ibus_rd_n,
  input  wire logic              ibus_read_write_dir,
  // Program counter
  input  wire logic              pc_valid,
  input  wire logic [DW-1:0]     cpu_pc,
  // X and Y buses
  input  wire logic              xbus_valid,
  input  wire logic [DW-1:0]     xbus_addr,
  input  wire logic [DW-1:0]     xbus_data,
  input  wire logic              ybus_valid,
  input  wire logic [DW-1:0]     ybus_addr,
  input  wire logic [DW-1:0]     ybus_data,
  // Break request to the CPU
  output logic                   break_req,
  input  wire logic              break_ack,
  output logic [CH_N-1:0]        break_chan,
  // Interrupt
  output logic                   irq
);
  // Register-side strobes
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DW-1:0]     wr_data;
  logic [3:0]        wr_strb;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DW-1:0]     rd_data;
  logic              rd_err;
  logic              wr_err;

  // Register state
  logic [DW-1:0]     ctrl_q   [CH_N];
  logic [DW-1:0]     caddr_q  [CH_N];
  logic [DW-1:0]     cdata_q  [CH_N];
  logic [CNT_W-1:0]  count_q  [CH_N];
  logic [CH_N-1:0]   reload_q;
  logic [CH_N-1:0]   reload_d;
  logic [CH_N-1:0]   sts_q;
  logic [CH_N-1:0]   sts_d;
  logic [CH_N-1:0]   mask_q;
  logic              brk_q;
  logic              brk_d;
  logic [CH_N-1:0]   bchan_q;
  logic [CH_N-1:0]   hit_vec;
  logic [CNT_W-1:0]  cnt_left [CH_N];

  bcm_axil u_axil (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_err    (wr_err),
    .rd_en     (rd_en),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_err    (rd_err)
  );

  // Address decode, word aligned
  wire [ADDR_W-1:0] wr_word = {wr_addr[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] rd_word = {rd_addr[ADDR_W-1:2], 2'b00};
  wire              wr_in_ch = (wr_word < CH_AREA_END);
  wire              rd_in_ch = (rd_word < CH_AREA_END);
  wire [ADDR_W-1:0] wr_off  = wr_word & CH_OFS_MASK;
  wire [ADDR_W-1:0] rd_off  = rd_word & CH_OFS_MASK;
  wire [1:0]        wr_idx  = wr_word[CH_IDX_LSB +: 2];
  wire [1:0]        rd_idx  = rd_word[CH_IDX_LSB +: 2];
  wire              wr_mask = wr_en && (wr_word == OFS_MASK);
  wire              rd_sts  = rd_en && (rd_word == OFS_STATUS);

  assign wr_err = !wr_in_ch && (wr_word != OFS_MASK) &&
                  (wr_word != OFS_STATUS) && (wr_word != OFS_BREAK);
  assign rd_err = !rd_in_ch && (rd_word != OFS_MASK) &&
                  (rd_word != OFS_STATUS) && (rd_word != OFS_BREAK);

  // Channel read view
  wire [DW-1:0] rd_ch =
    (rd_off == OFS_CTRL)  ? ctrl_q[rd_idx]  :
    (rd_off == OFS_ADDR)  ? caddr_q[rd_idx] :
    (rd_off == OFS_DATA)  ? cdata_q[rd_idx] :
    DW'(cnt_left[rd_idx]);

  assign rd_data =
    rd_in_ch                 ? rd_ch :
    (rd_word == OFS_STATUS)  ? DW'(sts_q) :
    (rd_word == OFS_MASK)    ? DW'(mask_q) :
    (rd_word == OFS_BREAK)   ? DW'({bchan_q, brk_q}) :
    '0;

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi = gi + 1) begin : g_ch
      wire sel_ch  = wr_en && wr_in_ch && (wr_idx == 2'(gi));
      wire wr_ctrl = sel_ch && (wr_off == OFS_CTRL);
      wire wr_addr_r = sel_ch && (wr_off == OFS_ADDR);
      wire wr_data_r = sel_ch && (wr_off == OFS_DATA);
      wire wr_cnt  = sel_ch && (wr_off == OFS_COUNT);
      wire [DW-1:0] cnt_wide = strb_merge(DW'(count_q[gi]), wr_data,
                                          wr_strb);

      // reload after control or count write
      assign reload_d[gi] = wr_ctrl || wr_cnt;

      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          ctrl_q[gi]  <= CTRL_RST;
          caddr_q[gi] <= '0;
          cdata_q[gi] <= '0;
          count_q[gi] <= '0;
        end else begin
          if (wr_ctrl) begin
            ctrl_q[gi] <= strb_merge(ctrl_q[gi], wr_data, wr_strb);
          end
          if (wr_addr_r) begin
            caddr_q[gi] <= strb_merge(caddr_q[gi], wr_data, wr_strb);
          end
          if (wr_data_r) begin
            cdata_q[gi] <= strb_merge(cdata_q[gi], wr_data, wr_strb);
          end
          if (wr_cnt) begin
            count_q[gi] <= cnt_wide[CNT_W-1:0];
          end
        end
      end

      wire [1:0] bsel = ctrl_q[gi][CB_BSEL +: 2];
      wire lb_all  = (bcm_bsel_t'(bsel) == BSEL_CPU_ALL);
      wire lb_data = (bcm_bsel_t'(bsel) == BSEL_CPU_DATA) && !lbus_ifetch;
      wire use_ib  = (bcm_bsel_t'(bsel) == BSEL_IBUS);
      wire bus_v   = use_ib ? ibus_valid : (lbus_valid && (lb_all || lb_data));
      wire [DW-1:0] bus_a  = use_ib ? ibus_addr : lbus_addr;
      wire [DW-1:0] bus_d  = use_ib ? ibus_data : lbus_data;
      wire [1:0]    bus_sz = use_ib ? ibus_size : lbus_size;
      wire bus_rdn  = use_ib ? ibus_rd_n : lbus_rd_n;
      wire bus_dir  = use_ib ? ibus_read_write_dir : lbus_read_write_dir;
      wire bcm_bst_t bus_t = use_ib ?
        bst_code(ibus_ifetch, ibus_dma, ibus_read_write_dir) :
        bst_code(lbus_ifetch, 1'b0, lbus_read_write_dir);

      wire use_xy  = ctrl_q[gi][CB_XY];
      wire use_y   = ctrl_q[gi][CB_XY_SEL];
      wire use_pc  = ctrl_q[gi][CB_ADDR_PC];
      wire xy_v    = use_y ? ybus_valid : xbus_valid;
      wire [DW-1:0] xy_a = use_y ? ybus_addr : xbus_addr;
      wire [DW-1:0] xy_d = use_y ? ybus_data : xbus_data;
      wire cyc_v   = use_xy ? xy_v : use_pc ? pc_valid : bus_v;
      wire [DW-1:0] cyc_a = use_xy ? xy_a : use_pc ? cpu_pc : bus_a;
      wire [DW-1:0] cyc_d = use_xy ? xy_d : bus_d;
      wire cyc_io  = !use_xy && ((bus_a & IO_MASK) == IO_BASE);

      bcm_chan #(
        .CNT_W (CNT_W)
      ) u_chan (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .ctrl      (ctrl_q[gi]),
        .cmp_addr  (caddr_q[gi]),
        .cmp_data  (cdata_q[gi]),
        .cnt_init  (count_q[gi]),
        .reload    (reload_q[gi]),
        .cyc_valid (cyc_v),
        .cyc_addr  (cyc_a),
        .cyc_data  (cyc_d),
        .cyc_size  (bus_sz),
        .cyc_rd_n  (bus_rdn),
        .cyc_read_write_dir  (bus_dir),
        .cyc_type  (bus_t),
        .cyc_io    (cyc_io),
        .hit       (hit_vec[gi]),
        .cnt_left  (cnt_left[gi])
      );
    end
  endgenerate

  // Sticky status, set wins over read clear
  assign sts_d = (rd_sts ? '0 : sts_q) | hit_vec;
  assign brk_d = (|hit_vec) || (brk_q && !break_ack);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reload_q <= '0;
      sts_q    <= '0;
      mask_q   <= '0;
      brk_q    <= 1'b0;
      bchan_q  <= '0;
    end else begin
      reload_q <= reload_d;
      sts_q    <= sts_d;
      brk_q    <= brk_d;
      if (wr_mask) begin
        mask_q <= wr_data[CH_N-1:0];
      end
      if (|hit_vec) begin
        bchan_q <= hit_vec;
      end
    end
  end

  assign break_req  = brk_q;
  assign break_chan = bchan_q;
  assign irq        = |(sts_q & mask_q);
endmodule
`default_nettype wire

/* File: bcm_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bcm_cpu_model
  import bcm_pkg::*;
(
  // Clock
  input  wire logic     clk_sys,
  // Processor-side bus
  output logic          lbus_valid, lbus_ifetch, lbus_rd_n,
  output logic          lbus_read_write_dir,
  output logic [DW-1:0] lbus_addr, lbus_data,
  output logic [1:0]    lbus_size,
  // Internal system bus
  output logic          ibus_valid, ibus_ifetch, ibus_dma, ibus_rd_n,
  output logic          ibus_read_write_dir,
  output logic [DW-1:0] ibus_addr, ibus_data,
  output logic [1:0]    ibus_size,
  // Program counter, X and Y buses
  output logic          pc_valid, xbus_valid, ybus_valid,
  output logic [DW-1:0] cpu_pc, xbus_addr, xbus_data, ybus_addr, ybus_data
);
  // Cycle bits: {dir, size, dma, fetch}
  task automatic put(input logic [4:0] v, input logic [4:0] cb,
                     input logic [DW-1:0] a, input logic [DW-1:0] d);
    {lbus_valid, ibus_valid, pc_valid, xbus_valid, ybus_valid} <= v;
    {lbus_ifetch, ibus_ifetch, ibus_dma} <= {cb[0], cb[0], cb[1]};
    {lbus_size, ibus_size} <= {2{cb[3:2]}};
    {lbus_read_write_dir, ibus_read_write_dir} <= {2{cb[4]}};
    {lbus_rd_n, ibus_rd_n} <= {2{~cb[4]}};
    {lbus_addr, ibus_addr, cpu_pc, xbus_addr, ybus_addr} <= {5{a}};
    {lbus_data, ibus_data, xbus_data, ybus_data} <= {4{d}};
  endtask

  initial put(5'h0, 5'h0, '0, '0);

  task automatic cyc(input int src, input logic [4:0] cb,
                     input logic [DW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    put(5'h10 >> src, cb, a, d);
    @(posedge clk_sys);
    // Released bus shows the inverse, never a stale match
    put(5'h0, ~cb, ~a, ~d);
  endtask
endmodule
`default_nettype wire

/* File: bcm_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module bcm_chk
  import bcm_pkg::*;
(
  // Clock and reset
  input wire logic            clk_sys, nrst,
  // Register bus
  input wire logic            s_awvalid, s_awready, s_wvalid, s_wready,
  input wire logic            s_bvalid, s_bready, s_arvalid, s_arready,
  input wire logic            s_rvalid, s_rready,
  input wire logic [1:0]      s_bresp,
  input wire logic [DW-1:0]   s_rdata,
  // Observed cycles and break
  input wire logic            lbus_valid, ibus_valid, pc_valid,
  input wire logic            xbus_valid, ybus_valid, break_req, break_ack,
  input wire logic [CH_N-1:0] break_chan
);
  logic any_v;
  assign any_v = lbus_valid | ibus_valid | pc_valid | xbus_valid | ybus_valid;
  default clocking dclk @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_brk_cause: assert property ($rose(break_req) |-> $past(any_v))
    else $error("break raised with no bus cycle");
  chk_chan_set: assert property ($rose(break_req) |-> |break_chan)
    else $error("break raised with no channel");
  chk_req_hold: assert property (break_req && !break_ack |=> break_req)
    else $error("break request dropped before ack");
  chk_ack_clear: assert property (break_ack && !any_v |=> !break_req)
    else $error("break request kept after ack");
  chk_chan_keep: assert property (!any_v |=> $stable(break_chan))
    else $error("channel changed without a cycle");
  chk_wr_answer: assert property (
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read response late");
  chk_b_hold: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response not held");
  chk_r_hold: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data not held");
  chk_busy_ready: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while response pending");
endmodule

bind bcm_top bcm_chk bcm_chk_i (.clk_sys(clk_sys), .nrst(nrst),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid),
  .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .s_bresp(s_bresp), .s_rdata(s_rdata),
  .lbus_valid(lbus_valid), .ibus_valid(ibus_valid), .pc_valid(pc_valid),
  .xbus_valid(xbus_valid), .ybus_valid(ybus_valid),
  .break_req(break_req), .break_ack(break_ack), .break_chan(break_chan));
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb
  import bcm_pkg::*;
;
  localparam logic [DW-1:0] EN = 32'h1 << CB_EN;
  localparam logic [DW-1:0] AD = 32'h1 << CB_ADDR;
  localparam logic [4:0] RD = 5'h18, WR = 5'h08, FE = 5'h19, DM = 5'h1a;
  localparam logic [8:0] BSX = 9'h113;
  logic clk_sys, nrst, break_req, break_ack, irq, pc_valid, xbus_valid;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, ybus_valid;
  logic lbus_valid, lbus_ifetch, lbus_rd_n, lbus_read_write_dir, ibus_dma;
  logic ibus_valid, ibus_ifetch, ibus_rd_n, ibus_read_write_dir;
  logic [ADDR_W-1:0] s_awaddr, s_araddr;
  logic [DW-1:0] s_wdata, s_rdata, lbus_addr, lbus_data, ibus_addr, ibus_data;
  logic [DW-1:0] cpu_pc, xbus_addr, xbus_data, ybus_addr, ybus_data, r;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, lbus_size, ibus_size;
  logic [CH_N-1:0] break_chan, stat_m;
  logic [4:0] typ[4];
  int unsigned reg_m[9];
  int fails, tests_run, t;

  bcm_top bcm_top_i (.*);
  bcm_cpu_model bcm_cpu_model_i (.*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end

  task automatic check(input string nm, input logic [DW-1:0] seen,
                       input logic [DW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Handshakes sampled at the falling edge, acted on at next rise
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [DW-1:0] d,
                     input logic [1:0] er, input bit slow = 0);
    logic ta, tw, b;
    logic [1:0] rb;
    @(posedge clk_sys);
    {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 2'h3, !slow};
    for (int n = 0; n < 40; n++) begin
      @(negedge clk_sys);
      {ta, tw} = {s_awvalid & s_awready, s_wvalid & s_wready};
      {b, rb} = {s_bvalid & s_bready, s_bresp};
      @(posedge clk_sys);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      if (slow && n == 4) s_bready <= 1'b1;
      if (b) break;
    end
    s_bready <= 1'b0;
    check("bresp", b ? rb : 2'hx, er);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DW-1:0] e,
                      input logic [1:0] er, input bit slow = 0);
    logic ta, b;
    logic [DW-1:0] d;
    logic [1:0] rs;
    @(posedge clk_sys);
    {s_araddr, s_arvalid, s_rready} <= {a, 1'b1, !slow};
    for (int n = 0; n < 40; n++) begin
      @(negedge clk_sys);
      {ta, b} = {s_arvalid & s_arready, s_rvalid & s_rready};
      {d, rs} = {s_rdata, s_rresp};
      @(posedge clk_sys);
      if (ta) s_arvalid <= 1'b0;
      if (slow && n == 4) s_rready <= 1'b1;
      if (b) break;
    end
    s_rready <= 1'b0;
    check("rdata", d, e);
    check("rresp", b ? rs : 2'hx, er);
  endtask

  task automatic ack();
    @(posedge clk_sys);
    break_ack <= 1'b1;
    @(posedge clk_sys);
    break_ack <= 1'b0;
    #1 check("break_req", break_req, 0);
  endtask

  task automatic probe(input int ch, input logic [DW-1:0] c, input int src,
                       input logic [DW-1:0] a, input logic [DW-1:0] d,
                       input logic [4:0] cb, input bit e);
    logic [ADDR_W-1:0] b;
    b = ADDR_W'(ch) << CH_IDX_LSB;
    axw(b + OFS_ADDR, r, RESP_OKAY);
    axw(b + OFS_DATA, r, RESP_OKAY);
    axw(b, c | EN, RESP_OKAY);
    bcm_cpu_model_i.cyc(src, cb, a, d);
    #1 check("break_req", break_req, e);
    if (e) begin
      check("break_chan", break_chan, 32'h1 << ch);
      stat_m[ch] = 1'b1;
    end
    ack();
    axw(b, 32'h0, RESP_OKAY);
  endtask

  initial begin
    nrst = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, break_ack} = '0;
    {s_awaddr, s_araddr, s_wdata, stat_m, fails, tests_run} = '0;
    s_wstrb = 4'hf;
    typ = '{FE, RD, WR, DM};
    r = $urandom(32'hf1ed);
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rchk(OFS_STATUS, 0, RESP_OKAY);
    rchk(OFS_BREAK, 0, RESP_OKAY, 1);
    rchk(8'h3c, 0, RESP_SLVERR);
    axw(8'h3c, r, RESP_SLVERR, 1);
    for (t = 0; t < 9; t++) begin
      reg_m[t] = $urandom & (t % 3 ? 32'hffff_ffff : 32'h8003_ffff);
      axw(ADDR_W'(t / 3 * 16 + t % 3 * 4), reg_m[t], RESP_OKAY);
    end
    for (t = 0; t < 9; t++) begin
      rchk(ADDR_W'(t / 3 * 16 + t % 3 * 4), reg_m[t], RESP_OKAY);
      if (t % 3 == 0) axw(ADDR_W'(t / 3 * 16), 0, RESP_OKAY);
    end
    r = $urandom;
    probe(0, AD, 0, r, ~r, RD, 1);
    probe(0, AD, 0, r ^ 32'h1, ~r, RD, 0);
    probe(1, AD | 32'h1 << CB_ADDR_PC, 2, r, ~r, RD, 1);
    probe(1, AD | 32'h1 << CB_ADDR_PC, 0, r, ~r, RD, 0);
    probe(2, 32'h1 << CB_DATA, 0, ~r, {~r[31:8], r[7:0]}, 5'h10, 1);
    probe(2, 32'h1 << CB_DATA, 0, ~r, {~r[31:8], r[7:0]}, 5'h14, 0);
    probe(2, 32'h3 << CB_DATA, 0, ~r, {~r[31:16], r[15:0]}, 5'h14, 1);
    probe(0, 32'h7 << CB_XY, 4, ~r, r, RD, 1);
    probe(0, 32'h7 << CB_XY, 3, ~r, r, RD, 0);
    probe(1, 32'h1 << CB_XY, 3, r, ~r, RD, 1);
    probe(1, 32'h7 << CB_RW, 0, r, r, RD, 1);
    probe(1, 32'h7 << CB_RW, 0, r, r, WR, 0);
    probe(1, 32'h1 << CB_RW, 0, r, r, RD, 1);
    probe(1, 32'h1 << CB_RW, 0, r, r, WR, 0);
    for (t = 0; t < 16; t++) begin
      probe(2, 32'h1 << CB_BST | DW'(t / 4) << CB_BTYPE | 32'h2 << CB_BSEL,
            1, r, r, typ[t % 4], t / 4 == t % 4);
    end
    for (t = 0; t < 9; t++) begin
      probe(0, AD | DW'(t / 3) << CB_BSEL, t % 3 / 2, r, r,
            typ[t % 3 * 3 / 2], BSX[t]);
    end
    probe(1, 32'h1 << CB_IO, 0, {8'hff, r[23:0]}, r, WR, 1);
    probe(1, 32'h1 << CB_IO, 0, {8'hfe, r[23:0]}, r, WR, 0);
    axw(OFS_COUNT, 32'h3, RESP_OKAY);
    axw(OFS_ADDR, r, RESP_OKAY);
    axw(OFS_CTRL, EN | AD | 32'h1 << CB_CNT, RESP_OKAY);
    for (t = 0; t < 4; t++) begin
      bcm_cpu_model_i.cyc(0, RD, r, r);
      #1 check("count", break_req, t == 2);
      if (t == 0) rchk(OFS_COUNT, 2, RESP_OKAY);
      if (t == 2) rchk(OFS_BREAK, 32'h3, RESP_OKAY);
      if (t == 2) ack();
    end
    stat_m[0] = 1'b1;
    axw(OFS_CTRL, 0, RESP_OKAY);
    #1 check("irq", irq, 0);
    axw(OFS_MASK, 32'h7, RESP_OKAY);
    #1 check("irq", irq, |stat_m);
    rchk(OFS_STATUS, stat_m, RESP_OKAY);
    #1 check("irq", irq, 0);
    axw(OFS_MASK, 32'h4, RESP_OKAY);
    probe(2, AD, 0, r, r, RD, 1);
    #1 check("irq", irq, 1);
    axw(OFS_MASK, 32'h3, RESP_OKAY);
    #1 check("irq", irq, 0);
    rchk(OFS_STATUS, 32'h4, RESP_OKAY);
    tally_and_finish();
  end
endmodule
`default_nettype wire
